// [verilog/sdcke_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module sdcke_ctrl
	import sdcke_pkg::*;
(
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	// pins from the controller
	input  wire logic         cke_i,
	input  wire sdcke_cmd_s   cmd_i,
	// bank status from the command decoder
	input  wire logic         all_banks_idle_i,
	input  wire logic         row_open_i,
	// status
	output logic [2:0]        state_o,
	output logic              decode_en_o,
	output logic              self_refresh_o,
	output logic              power_down_o,
	output logic              suspend_o,
	output logic              illegal_o,
	output logic              invalid_o
);

	logic          cke_meta_ff;
	logic          cke_sync_ff;
	logic          cke_prev_ff;
	logic          wake_ff;
	logic          wake_clr_ff;
	logic          wake_rst_n;
	logic          wake_meta_ff;
	logic          wake_sync_ff;
	sdcke_state_e  state_ff;
	sdcke_state_e  nxt_state;
	logic [3:0]    cnt_ff;
	logic [3:0]    nxt_cnt;
	logic          illegal_ff;
	logic          nxt_illegal;
	logic          invalid_ff;
	logic          nxt_invalid;
	logic          decode_ff;
	logic          nxt_decode;
	logic          low_power;

	assign low_power = (state_ff == SDCKE_SREF) || (state_ff == SDCKE_PDOWN);

	// latch is held clear while awake, so every sleep is armed afresh
	assign wake_rst_n = reset_n_i & ~wake_clr_ff;

	// rising edge of clock enable latched with no clock while asleep
	always_ff @(posedge cke_i or negedge wake_rst_n) begin
		if (!wake_rst_n) begin
			wake_ff <= 1'b0;
		end else begin
			wake_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cke_meta_ff  <= 1'b0;
			cke_sync_ff  <= 1'b0;
			cke_prev_ff  <= 1'b0;
			wake_meta_ff <= 1'b0;
			wake_sync_ff <= 1'b0;
			wake_clr_ff  <= 1'b1;
		end else begin
			wake_clr_ff  <= ~low_power;
			cke_meta_ff  <= cke_i;
			cke_sync_ff  <= cke_meta_ff;
			cke_prev_ff  <= cke_sync_ff;
			wake_meta_ff <= wake_ff;
			wake_sync_ff <= wake_meta_ff;
		end
	end

	always_comb begin
		nxt_state   = state_ff;
		nxt_cnt     = cnt_ff;
		nxt_illegal = 1'b0;
		nxt_invalid = 1'b0;
		nxt_decode  = cke_prev_ff & cke_sync_ff;
		case (state_ff)
			SDCKE_IDLE: begin
				if (cke_prev_ff && !cke_sync_ff) begin
					if (sdcke_is_sref(cmd_i)) begin
						nxt_state = SDCKE_SREF;
					end else if (sdcke_is_nop(cmd_i)) begin
						nxt_state = SDCKE_PDOWN;
					end else begin
						nxt_illegal = 1'b1;
					end
				end else if (row_open_i) begin
					nxt_state = SDCKE_ACTIVE;
				end
			end
			SDCKE_ACTIVE: begin
				if (cke_prev_ff && !cke_sync_ff) begin
					nxt_state = SDCKE_SUSPEND;
				end else if (all_banks_idle_i) begin
					nxt_state = SDCKE_IDLE;
				end
			end
			SDCKE_SUSPEND: begin
				if (cke_sync_ff) begin
					nxt_state = SDCKE_ACTIVE;
				end
			end
			SDCKE_PDOWN: begin
				if (cke_prev_ff) begin
					nxt_invalid = 1'b1;
				end
				if (cke_sync_ff || wake_sync_ff) begin
					nxt_state   = SDCKE_IDLE;
					nxt_illegal = ~sdcke_is_nop(cmd_i);
				end
			end
			SDCKE_SREF: begin
				if (cke_prev_ff) begin
					nxt_invalid = 1'b1;
				end
				// other pins are don't-care while asleep
				if (cke_sync_ff || wake_sync_ff) begin
					nxt_state   = SDCKE_SREXIT;
					nxt_cnt     = SDCKE_REFRESH_CYCLE_TIME_CYC;
					nxt_illegal = ~sdcke_is_nop(cmd_i);
				end
			end
			SDCKE_SREXIT: begin
				nxt_decode = 1'b0;
				if (cnt_ff <= 4'h1) begin
					nxt_state = SDCKE_IDLE;
					nxt_cnt   = SDCKE_CNT_RST;
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
				if (!sdcke_is_nop(cmd_i)) begin
					nxt_illegal = 1'b1;
				end
			end
			default: begin
				nxt_state = SDCKE_IDLE;
			end
		endcase
		if (low_power) begin
			nxt_decode = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff   <= SDCKE_IDLE;
			cnt_ff     <= SDCKE_CNT_RST;
			illegal_ff <= 1'b0;
			invalid_ff <= 1'b0;
			decode_ff  <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			illegal_ff <= nxt_illegal;
			invalid_ff <= nxt_invalid;
			decode_ff  <= nxt_decode;
		end
	end

	// registered status copies
	logic        sref_ff;
	logic        pdown_ff;
	logic        susp_ff;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sref_ff  <= 1'b0;
			pdown_ff <= 1'b0;
			susp_ff  <= 1'b0;
		end else begin
			sref_ff  <= (nxt_state == SDCKE_SREF);
			pdown_ff <= (nxt_state == SDCKE_PDOWN);
			susp_ff  <= (nxt_state == SDCKE_SUSPEND);
		end
	end

	assign state_o        = state_ff;
	assign decode_en_o    = decode_ff;
	assign self_refresh_o = sref_ff;
	assign power_down_o   = pdown_ff;
	assign suspend_o      = susp_ff;
	assign illegal_o      = illegal_ff;
	assign invalid_o      = invalid_ff;

endmodule
`default_nettype wire

// [verilog/sdcke_pkg.sv]
package sdcke_pkg;

	typedef enum logic [2:0] {
		SDCKE_IDLE    = 3'h0,
		SDCKE_ACTIVE  = 3'h1,
		SDCKE_SUSPEND = 3'h3,
		SDCKE_PDOWN   = 3'h2,
		SDCKE_SREF    = 3'h6,
		SDCKE_SREXIT  = 3'h7
	} sdcke_state_e;

	// command pins, all active low
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} sdcke_cmd_s;

	// refresh cycle time, in ns
	localparam int          SDCKE_REFRESH_CYCLE_TIME_NS = 60;
	localparam int          SDCKE_CLK_PERIOD_NS         = 20;
	localparam int          SDCKE_REFRESH_CYCLE_TIME_CYC_INT =
		(SDCKE_REFRESH_CYCLE_TIME_NS + SDCKE_CLK_PERIOD_NS - 1)
		/ SDCKE_CLK_PERIOD_NS;
	localparam logic [3:0]  SDCKE_REFRESH_CYCLE_TIME_CYC = 4'(SDCKE_REFRESH_CYCLE_TIME_CYC_INT);
	localparam logic [3:0]  SDCKE_CNT_RST  = 4'h0;

	// deselect or nop, the only codes legal on an exit
	function automatic logic sdcke_is_nop(input sdcke_cmd_s c);
		return c.cs_n | (c.ras_n & c.cas_n & c.we_n);
	endfunction

	function automatic logic sdcke_is_sref(input sdcke_cmd_s c);
		return ~c.cs_n & ~c.ras_n & ~c.cas_n & c.we_n;
	endfunction

endpackage

// [verif/sdcke_ctrl_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module sdcke_ctrl_assertions
	import sdcke_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	input wire logic       cke_i,
	input wire logic [2:0] state_o,
	input wire logic       self_refresh_o,
	input wire logic       decode_en_o,
	input wire logic       power_down_o,
	input wire logic       suspend_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	AST_SREF_FLAG:
	assert property (state_o == SDCKE_SREF |-> self_refresh_o && !decode_en_o)
		else $error("self refresh flags wrong");
	AST_SREF_HOLD:
	assert property (state_o == SDCKE_SREF && !cke_i && !$past(cke_i)
		&& !$past(cke_i, 2) |=> state_o == SDCKE_SREF) else $error("sref lost");
	AST_PD_HOLD:
	assert property (state_o == SDCKE_PDOWN && !cke_i && !$past(cke_i)
		&& !$past(cke_i, 2) |=> state_o == SDCKE_PDOWN && power_down_o)
		else $error("power down lost");
	AST_SUSP_ENTRY:
	assert property ((state_o == SDCKE_ACTIVE && !cke_i)[*3]
		|-> ##[0:3] state_o == SDCKE_SUSPEND) else $error("no suspend");
	AST_SUSP_HOLD:
	assert property (state_o == SDCKE_SUSPEND && !cke_i && !$past(cke_i)
		&& !$past(cke_i, 2) |=> state_o == SDCKE_SUSPEND && suspend_o)
		else $error("suspend lost");
	AST_SUSP_EXIT:
	assert property ((state_o == SDCKE_SUSPEND && cke_i)[*3]
		|-> ##[0:3] state_o == SDCKE_ACTIVE) else $error("suspend stuck");
	AST_REFRESH_CYCLE_TIME_MIN:
	assert property ($rose(state_o == SDCKE_SREXIT)
		|-> (state_o == SDCKE_SREXIT)[*3]) else $error("refresh too short");
	AST_REFRESH_CYCLE_TIME_MAX:
	assert property ($rose(state_o == SDCKE_SREXIT)
		|-> ##[3:6] state_o == SDCKE_IDLE) else $error("refresh too long");
	cover property (state_o == SDCKE_SREF);
	cover property (state_o == SDCKE_PDOWN);
	cover property (state_o == SDCKE_SUSPEND);
endmodule
bind sdcke_ctrl sdcke_ctrl_assertions chk_i (.clk_i(clk_i),
	.reset_n_i(reset_n_i), .cke_i(cke_i), .state_o(state_o),
	.self_refresh_o(self_refresh_o), .decode_en_o(decode_en_o),
	.power_down_o(power_down_o), .suspend_o(suspend_o));
`default_nettype wire

// [verif/sdcke_ctrl_model.sv]
`timescale 1ns/100ps
`default_nettype none
module sdcke_ctrl_model
	import sdcke_pkg::*;
(
	input  wire logic       clk_i,
	output var  logic       cke_o,
	output var  sdcke_cmd_s cmd_o
);
	initial begin
		cke_o = 1'b1;
		cmd_o = 4'hf;
	end
	// pins move just after an edge and hold until the next call
	task automatic drive(input logic c, input logic [3:0] k);
		@(posedge clk_i);
		#1;
		cke_o = c;
		cmd_o = k;
	endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import sdcke_pkg::*;
	logic       clk_i = 0;
	logic       reset_n_i = 0;
	logic       idle_b = 1;
	logic       row = 0;
	logic       cke, sr, pd, su, ill, inv, dec;
	sdcke_cmd_s cmd;
	logic [2:0] st;
	int         err_count = 0;
	int         checks = 0;
	always #10 clk_i = ~clk_i;
	sdcke_ctrl_model ctl (.clk_i(clk_i), .cke_o(cke), .cmd_o(cmd));
	sdcke_ctrl uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .cke_i(cke),
		.cmd_i(cmd), .all_banks_idle_i(idle_b), .row_open_i(row),
		.state_o(st), .decode_en_o(dec), .self_refresh_o(sr),
		.power_down_o(pd), .suspend_o(su), .illegal_o(ill), .invalid_o(inv));
	task automatic give_verdict();
		if (err_count == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [2:0] e, input logic [2:0] g);
		checks++;
		if (e !== g) begin
			err_count++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wait_st(input logic [2:0] e);
		int n;
		n = 0;
		while (st !== e && n < 12) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk("state", e, st);
		if (n >= 12) give_verdict();
	endtask
	// enter a sleep state, hold it with junk commands, leave with ex
	task automatic sc_sleep(input logic [3:0] ent, input logic [2:0] s,
		input logic [3:0] ex);
		int n;
		int m;
		logic f;
		ctl.drive(1'b0, ent);
		wait_st(s);
		chk("self_refresh", 3'(s == SDCKE_SREF), 3'(sr));
		chk("power_down", 3'(s == SDCKE_PDOWN), 3'(pd));
		chk("decode_sleep", 3'h0, 3'(dec));
		repeat (4) ctl.drive(1'b0, 4'h4);
		chk("hold", s, st);
		ctl.drive(1'b1, ex);
		n = 0;
		m = 0;
		f = 1'b0;
		while (st !== SDCKE_IDLE && n < 12) begin
			@(posedge clk_i);
			#1;
			n++;
			m += (st === SDCKE_SREXIT);
			f |= ill | inv;
		end
		chk("idle", SDCKE_IDLE, st);
		if (n >= 12) give_verdict();
		chk("refresh_cycle_time", 3'(s == SDCKE_SREF), 3'(m >= SDCKE_REFRESH_CYCLE_TIME_CYC));
		chk("illegal", 3'(ex != 4'h7 && ex != 4'hf), 3'(f));
		ctl.drive(1'b1, 4'h7);
		ctl.drive(1'b1, 4'h7);
		chk("decode_idle", 3'h1, 3'(dec));
	endtask
	task automatic sc_susp();
		row = 1'b1;
		idle_b = 1'b0;
		wait_st(SDCKE_ACTIVE);
		ctl.drive(1'b0, 4'h7);
		wait_st(SDCKE_SUSPEND);
		repeat (3) ctl.drive(1'b0, 4'h7);
		chk("susp", SDCKE_SUSPEND, st);
		chk("susp_o", 3'h1, 3'(su));
		ctl.drive(1'b1, 4'h7);
		wait_st(SDCKE_ACTIVE);
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		#1 reset_n_i = 1'b1;
		repeat (3) @(posedge clk_i);
		#1 chk("reset", SDCKE_IDLE, st);
		sc_sleep(4'h1, SDCKE_SREF, 4'h7);
		sc_sleep(4'h7, SDCKE_PDOWN, 4'hf);
		sc_sleep(4'h1, SDCKE_SREF, 4'h5);
		sc_sleep(4'hf, SDCKE_PDOWN, 4'h4);
		sc_susp();
		give_verdict();
	end
endmodule
`default_nettype wire
